//--- src/iacl_entry.sv
// Functional notes
// - IPv4 criteria apply only to IPv4 frames with frame type set to IPv4.
// - Protocol any ignores the protocol number.
// - Protocol specific needs equality with the configured 8-bit value.
// - Protocol ICMP matches ICMP frames only and flags ICMP criteria enabled.
// - Protocol UDP matches UDP frames only and flags port criteria enabled.
// - Protocol TCP matches TCP frames only and flags TCP criteria enabled.
// - Lifetime zero refuses frames with TTL above zero.
// - Any setting makes lifetime, fragment, options don't-care.
// - Fragment no refuses frames with MF set or offset nonzero.
// - Fragment yes allows only frames with MF set or offset nonzero.
// - Options no refuses frames carrying options.
// - Options yes allows only frames carrying options.
// - Source any ignores the source address.
// - Source host needs exact equality with configured source address.
// - Source network matches against configured address and mask.
// - Destination any ignores the destination address.
// - Destination host needs exact equality with configured address.
// - Destination network matches against configured address and mask.
`timescale 1ns/100ps
`default_nettype none

module iacl_entry
#(
  parameter int unsigned ADDR_WIDTH = iacl_pkg::ADDR_W
) (
  input  wire logic                           clock_i,
  input  wire logic                           rst_b_i,
  // Entry configuration
  input  wire iacl_pkg::iacl_ftype_t          frame_type_i,
  input  wire iacl_pkg::iacl_proto_t          proto_mode_i,
  input  wire logic [iacl_pkg::PROTO_W-1:0]   proto_value_i,
  input  wire iacl_pkg::iacl_tri_t            ttl_mode_i,
  input  wire iacl_pkg::iacl_tri_t            frag_mode_i,
  input  wire iacl_pkg::iacl_tri_t            opt_mode_i,
  input  wire iacl_pkg::iacl_addr_t           src_mode_i,
  input  wire logic [ADDR_WIDTH-1:0]          source_ipv4_address_i,
  input  wire logic [ADDR_WIDTH-1:0]          source_ipv4_mask_i,
  input  wire iacl_pkg::iacl_addr_t           dst_mode_i,
  input  wire logic [ADDR_WIDTH-1:0]          destination_ipv4_address_i,
  input  wire logic [ADDR_WIDTH-1:0]          destination_ipv4_mask_i,
  // Parsed header from the frame parser
  input  wire logic                           hdr_valid_i,
  input  wire logic                           hdr_is_ipv4_i,
  input  wire logic [iacl_pkg::PROTO_W-1:0]   hdr_proto_i,
  input  wire logic [iacl_pkg::TTL_W-1:0]     hdr_ttl_i,
  input  wire logic                           hdr_mf_i,
  input  wire logic [iacl_pkg::FRAG_W-1:0]    hdr_frag_off_i,
  input  wire logic                           hdr_options_i,
  input  wire logic [ADDR_WIDTH-1:0]          hdr_src_i,
  input  wire logic [ADDR_WIDTH-1:0]          hdr_dst_i,
  // Result
  output logic                                hit_valid_o,
  output logic                                hit_o,
  output logic                                icmp_crit_en_o,
  output logic                                port_crit_en_o,
  output logic                                tcp_crit_en_o
);

  import iacl_pkg::*;

  // Named slots of the repeated decoders
  localparam int unsigned ADR_SRC  = 0;
  localparam int unsigned ADR_DST  = 1;
  localparam int unsigned N_ADR    = 2;
  localparam int unsigned TRI_TTL  = 0;
  localparam int unsigned TRI_FRAG = 1;
  localparam int unsigned TRI_OPT  = 2;
  localparam int unsigned N_TRI    = 3;
  localparam int unsigned EN_ICMP  = 0;
  localparam int unsigned EN_UDP   = 1;
  localparam int unsigned EN_TCP   = 2;
  localparam int unsigned N_EN     = 3;
  localparam int unsigned N_CRIT   = N_ADR + N_TRI + 2;

  // Protocol modes that open extra criteria, one per enable slot
  localparam iacl_proto_t EN_MODE [N_EN] = '{IACL_PR_ICMP, IACL_PR_UDP, IACL_PR_TCP};

  if (ADDR_WIDTH != ADDR_W) begin : g_chk
    $error("iacl_entry: ADDR_WIDTH must equal 32");
  end

  // Result register image
  typedef struct packed {
    iacl_state_t st;
    logic        vld;
    logic        hit;
    logic        icmp_en;
    logic        port_en;
    logic        tcp_en;
  } iacl_regs_t;

  // Reset image: idle, no result
  localparam iacl_regs_t REGS_RST = '{
    st:      IACL_ST_IDLE,
    vld:     1'b0,
    hit:     1'b0,
    icmp_en: 1'b0,
    port_en: 1'b0,
    tcp_en:  1'b0
  };

  iacl_regs_t r_q;
  iacl_regs_t r_d;

  // Address criterion decode, used for source and destination
  function automatic logic addr_ok(input iacl_addr_t        mode,
                                   input logic [ADDR_W-1:0] frm,
                                   input logic [ADDR_W-1:0] cfg,
                                   input logic [ADDR_W-1:0] msk);
    logic ok;
    ok = 1'b0;
    case (mode)
      IACL_AD_ANY: begin
        ok = 1'b1;
      end
      IACL_AD_HOST: begin
        ok = (frm == cfg);
      end
      IACL_AD_NET: begin
        ok = ((frm & msk) == (cfg & msk));
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction : addr_ok

  // Three-way condition decode, used for TTL, fragment and options
  function automatic logic tri_ok(input iacl_tri_t mode,
                                  input logic      cond);
    logic ok;
    ok = 1'b0;
    case (mode)
      IACL_TRI_ANY: begin
        ok = 1'b1;
      end
      IACL_TRI_NO: begin
        ok = !cond;
      end
      IACL_TRI_YES: begin
        ok = cond;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction : tri_ok

  // Per-criterion results
  logic                proto_ok;
  logic                ipv4_ok;
  iacl_addr_t          adr_mode [N_ADR];
  logic [ADDR_W-1:0]   adr_frm  [N_ADR];
  logic [ADDR_W-1:0]   adr_cfg  [N_ADR];
  logic [ADDR_W-1:0]   adr_msk  [N_ADR];
  logic [N_ADR-1:0]    adr_hit;
  iacl_tri_t           tri_mode [N_TRI];
  logic [N_TRI-1:0]    tri_cond;
  logic [N_TRI-1:0]    tri_hit;
  logic [N_EN-1:0]     en_hit;
  logic [N_CRIT-1:0]   crit_ok;

  // Protocol criterion
  always_comb begin
    proto_ok = 1'b0;
    case (proto_mode_i)
      IACL_PR_ANY: begin
        proto_ok = 1'b1;
      end
      IACL_PR_SPEC: begin
        proto_ok = (hdr_proto_i == proto_value_i);
      end
      IACL_PR_ICMP: begin
        proto_ok = (hdr_proto_i == PROTO_ICMP);
      end
      IACL_PR_UDP: begin
        proto_ok = (hdr_proto_i == PROTO_UDP);
      end
      IACL_PR_TCP: begin
        proto_ok = (hdr_proto_i == PROTO_TCP);
      end
      default: begin
        proto_ok = 1'b0;
      end
    endcase
  end

  assign ipv4_ok = hdr_is_ipv4_i && (frame_type_i == IACL_FT_IPV4);

  assign adr_mode[ADR_SRC] = src_mode_i;
  assign adr_frm[ADR_SRC]  = hdr_src_i;
  assign adr_cfg[ADR_SRC]  = source_ipv4_address_i;
  assign adr_msk[ADR_SRC]  = source_ipv4_mask_i;

  assign adr_mode[ADR_DST] = dst_mode_i;
  assign adr_frm[ADR_DST]  = hdr_dst_i;
  assign adr_cfg[ADR_DST]  = destination_ipv4_address_i;
  assign adr_msk[ADR_DST]  = destination_ipv4_mask_i;

  for (genvar g = 0; g < N_ADR; g++) begin : g_adr
    assign adr_hit[g] = addr_ok(adr_mode[g], adr_frm[g], adr_cfg[g], adr_msk[g]);
  end

  assign tri_mode[TRI_TTL]  = ttl_mode_i;
  assign tri_cond[TRI_TTL]  = (hdr_ttl_i != '0);

  assign tri_mode[TRI_FRAG] = frag_mode_i;
  assign tri_cond[TRI_FRAG] = hdr_mf_i || (hdr_frag_off_i != '0);

  assign tri_mode[TRI_OPT]  = opt_mode_i;
  assign tri_cond[TRI_OPT]  = hdr_options_i;

  for (genvar g = 0; g < N_TRI; g++) begin : g_tri
    assign tri_hit[g] = tri_ok(tri_mode[g], tri_cond[g]);
  end

  for (genvar g = 0; g < N_EN; g++) begin : g_en
    assign en_hit[g] = ipv4_ok && (proto_mode_i == EN_MODE[g]);
  end

  assign crit_ok = {ipv4_ok, proto_ok, tri_hit, adr_hit};

  // Header taken on each valid cycle, result one cycle later
  always_comb begin
    r_d = r_q;
    case (r_q.st)
      IACL_ST_IDLE: begin
        if (hdr_valid_i) begin
          r_d.st = IACL_ST_EVAL;
        end
      end
      IACL_ST_EVAL: begin
        if (!hdr_valid_i) begin
          r_d.st = IACL_ST_IDLE;
        end
      end
      default: begin
        r_d.st = IACL_ST_IDLE;
      end
    endcase
    // Result valid follows the next state
    r_d.vld = (r_d.st == IACL_ST_EVAL);
    if (hdr_valid_i) begin
      r_d.hit     = &crit_ok;
      r_d.icmp_en = en_hit[EN_ICMP];
      r_d.port_en = en_hit[EN_UDP];
      r_d.tcp_en  = en_hit[EN_TCP];
    end
  end

  // Asynchronous reset to the idle image
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r_q <= REGS_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from the result register
  assign hit_valid_o    = r_q.vld;
  assign hit_o          = r_q.hit;
  assign icmp_crit_en_o = r_q.icmp_en;
  assign port_crit_en_o = r_q.port_en;
  assign tcp_crit_en_o  = r_q.tcp_en;

endmodule : iacl_entry

`default_nettype wire

//--- src/iacl_pkg.sv
package iacl_pkg;

  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned PROTO_W   = 8;
  localparam int unsigned TTL_W     = 8;
  localparam int unsigned FRAG_W    = 13;

  // IPv4 protocol numbers
  localparam logic [PROTO_W-1:0] PROTO_ICMP = 8'h01;
  localparam logic [PROTO_W-1:0] PROTO_TCP  = 8'h06;
  localparam logic [PROTO_W-1:0] PROTO_UDP  = 8'h11;

  // Frame type selection of the entry
  typedef enum logic [1:0] {
    IACL_FT_ANY  = 2'h0,
    IACL_FT_IPV4 = 2'h1,
    IACL_FT_OTH  = 2'h2
  } iacl_ftype_t;

  // Protocol criterion
  typedef enum logic [2:0] {
    IACL_PR_ANY  = 3'h0,
    IACL_PR_SPEC = 3'h1,
    IACL_PR_ICMP = 3'h2,
    IACL_PR_UDP  = 3'h3,
    IACL_PR_TCP  = 3'h4
  } iacl_proto_t;

  // Three-way criterion: any, zero/no, nonzero/yes
  typedef enum logic [1:0] {
    IACL_TRI_ANY = 2'h0,
    IACL_TRI_NO  = 2'h1,
    IACL_TRI_YES = 2'h2
  } iacl_tri_t;

  // Address criterion
  typedef enum logic [1:0] {
    IACL_AD_ANY  = 2'h0,
    IACL_AD_HOST = 2'h1,
    IACL_AD_NET  = 2'h2
  } iacl_addr_t;

  // Result pipeline states, Gray ordered
  typedef enum logic [1:0] {
    IACL_ST_IDLE = 2'h0,
    IACL_ST_EVAL = 2'h1
  } iacl_state_t;

endpackage : iacl_pkg

//--- sim/iacl_parser_model.sv
`timescale 1ns/100ps
`default_nettype none
module iacl_parser_model (
  input  wire logic        clock_i,
  input  wire logic        send_i,
  input  wire logic [95:0] hdr_i,
  output logic             hdr_valid_o,
  output logic [95:0]      hdr_o
);
  initial hdr_valid_o = 1'b0;
  initial hdr_o = 96'h0;
  // One header per send; fields scrambled while not valid
  always @(posedge clock_i) begin
    hdr_valid_o <= send_i;
    hdr_o       <= send_i ? hdr_i : ~hdr_o;
  end
endmodule : iacl_parser_model
`default_nettype wire

//--- sim/iacl_entry_props.sv
`timescale 1ns/100ps
`default_nettype none
module iacl_entry_props
  import iacl_pkg::*;
(
  input wire logic                  clock_i,
  input wire logic                  rst_b_i,
  input wire iacl_pkg::iacl_ftype_t frame_type_i,
  input wire iacl_pkg::iacl_proto_t proto_mode_i,
  input wire logic [7:0]            proto_value_i,
  input wire iacl_pkg::iacl_tri_t   ttl_mode_i,
  input wire logic                  hdr_valid_i,
  input wire logic                  hdr_is_ipv4_i,
  input wire logic [7:0]            hdr_proto_i,
  input wire logic [7:0]            hdr_ttl_i,
  input wire logic                  hit_valid_o,
  input wire logic                  hit_o,
  input wire logic                  icmp_crit_en_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire logic tk = hdr_valid_i && frame_type_i == IACL_FT_IPV4 && hdr_is_ipv4_i;
  a_valid_follows: assert property (hdr_valid_i |=> hit_valid_o)
    else $error("result valid missing");
  a_result_held: assert property (!hdr_valid_i |=> !hit_valid_o && $stable(hit_o))
    else $error("result not held");
  a_non_ipv4: assert property (hdr_valid_i && !tk |=> !hit_o)
    else $error("hit outside IPv4");
  a_spec_proto: assert property (tk && proto_mode_i == IACL_PR_SPEC
    && hdr_proto_i != proto_value_i |=> !hit_o) else $error("specific protocol hit");
  a_icmp_enable: assert property (tk && proto_mode_i == IACL_PR_ICMP |=> icmp_crit_en_o)
    else $error("icmp enable missing");
  a_icmp_proto: assert property (tk && proto_mode_i == IACL_PR_ICMP
    && hdr_proto_i != PROTO_ICMP |=> !hit_o) else $error("icmp mode hit");
  a_ttl_zero: assert property (tk && ttl_mode_i == IACL_TRI_NO
    && hdr_ttl_i != 8'h00 |=> !hit_o) else $error("ttl zero mode hit");
  a_ttl_nonzero: assert property (tk && ttl_mode_i == IACL_TRI_YES
    && hdr_ttl_i == 8'h00 |=> !hit_o) else $error("ttl nonzero mode hit");
  c_hit: cover property (tk ##1 hit_o);
  c_ttl_hit: cover property (tk && ttl_mode_i == IACL_TRI_YES ##1 hit_o);
  c_icmp: cover property (tk && proto_mode_i == IACL_PR_ICMP);
endmodule : iacl_entry_props
bind iacl_entry iacl_entry_props u_props (.clock_i, .rst_b_i, .frame_type_i, .proto_mode_i,
  .proto_value_i, .ttl_mode_i, .hdr_valid_i, .hdr_is_ipv4_i, .hdr_proto_i, .hdr_ttl_i,
  .hit_valid_o, .hit_o, .icmp_crit_en_o);
`default_nettype wire

//--- sim/ipv4_acl_entry_matcher_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ipv4_acl_entry_matcher_tb;
  import iacl_pkg::*;
  logic clock_i = 1'b0, rst_b_i = 1'b0, send = 1'b0, ip, mf, opt;
  iacl_ftype_t frame_type_i = IACL_FT_ANY;
  iacl_proto_t proto_mode_i = IACL_PR_ANY;
  iacl_tri_t ttl_mode_i = IACL_TRI_ANY, frag_mode_i = IACL_TRI_ANY, opt_mode_i = IACL_TRI_ANY;
  iacl_addr_t src_mode_i = IACL_AD_ANY, dst_mode_i = IACL_AD_ANY;
  logic [7:0] proto_value_i = 8'h00, pro, ttl;
  logic [7:0] pt [4] = '{PROTO_ICMP, PROTO_TCP, PROTO_UDP, 8'hFF};
  logic [31:0] source_ipv4_address_i = '0, source_ipv4_mask_i = '0, s, d;
  logic [31:0] destination_ipv4_address_i = '0, destination_ipv4_mask_i = '0;
  logic [12:0] off, hdr_frag_off_i;
  logic [7:0] hdr_proto_i, hdr_ttl_i;
  logic [31:0] hdr_src_i, hdr_dst_i;
  logic [3:0] e = 4'h0;
  logic hdr_valid_i, hdr_is_ipv4_i, hdr_mf_i, hdr_options_i;
  logic hit_valid_o, hit_o, icmp_crit_en_o, port_crit_en_o, tcp_crit_en_o;
  int miscompares = 0, cmp_count = 0;
  iacl_parser_model u_model (.clock_i, .send_i(send), .hdr_i({ip, pro, ttl, mf, off, opt, s, d}),
    .hdr_valid_o(hdr_valid_i), .hdr_o({hdr_is_ipv4_i, hdr_proto_i, hdr_ttl_i, hdr_mf_i,
    hdr_frag_off_i, hdr_options_i, hdr_src_i, hdr_dst_i}));
  iacl_entry u_dut (.clock_i, .rst_b_i, .frame_type_i, .proto_mode_i, .proto_value_i,
    .ttl_mode_i, .frag_mode_i, .opt_mode_i, .src_mode_i, .source_ipv4_address_i,
    .source_ipv4_mask_i, .dst_mode_i, .destination_ipv4_address_i, .destination_ipv4_mask_i,
    .hdr_valid_i, .hdr_is_ipv4_i, .hdr_proto_i, .hdr_ttl_i, .hdr_mf_i, .hdr_frag_off_i,
    .hdr_options_i, .hdr_src_i, .hdr_dst_i, .hit_valid_o, .hit_o, .icmp_crit_en_o,
    .port_crit_en_o, .tcp_crit_en_o);
  // any, else condition must equal the yes setting
  function automatic logic tri_ok(iacl_tri_t m, logic c);
    return m == IACL_TRI_ANY || (m == IACL_TRI_YES) == c;
  endfunction : tri_ok
  // masked compare only where mask is one
  function automatic logic adr_ok(iacl_addr_t m, logic [31:0] a, c, k);
    return m == IACL_AD_ANY || (m == IACL_AD_HOST ? a == c : ((a ^ c) & k) == 0);
  endfunction : adr_ok
  function automatic logic [3:0] exp_out();
    logic g;
    logic [7:0] w;
    g = frame_type_i == IACL_FT_IPV4 && ip;
    w = proto_mode_i == IACL_PR_SPEC ? proto_value_i : proto_mode_i == IACL_PR_ICMP ?
      PROTO_ICMP : proto_mode_i == IACL_PR_UDP ? PROTO_UDP : PROTO_TCP;
    return {g && (proto_mode_i == IACL_PR_ANY || pro == w) && tri_ok(ttl_mode_i, ttl != 0)
      && tri_ok(frag_mode_i, mf || off != 0) && tri_ok(opt_mode_i, opt)
      && adr_ok(src_mode_i, s, source_ipv4_address_i, source_ipv4_mask_i)
      && adr_ok(dst_mode_i, d, destination_ipv4_address_i, destination_ipv4_mask_i),
      g && proto_mode_i == IACL_PR_ICMP, g && proto_mode_i == IACL_PR_UDP,
      g && proto_mode_i == IACL_PR_TCP};
  endfunction : exp_out
  task automatic chk(string n, logic [3:0] v, logic [3:0] x);
    cmp_count++;
    if (v !== x) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, x, v);
    end
  endtask : chk
  task automatic close_out();
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial forever #4 clock_i = ~clock_i;
  initial begin
    void'($urandom(32'hA00A));
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 600; i++) begin
      @(posedge clock_i);
      ip = $urandom_range(0, 3) != 0;
      pro = pt[$urandom_range(0, 3)];
      ttl = 8'($urandom_range(0, 2));
      mf = 1'($urandom_range(0, 1));
      off = 13'($urandom_range(0, 2) == 0);
      opt = 1'($urandom_range(0, 1));
      s = $urandom;
      d = $urandom;
      frame_type_i <= iacl_ftype_t'(($urandom_range(0, 3) + 1) % 3);
      proto_mode_i <= iacl_proto_t'($urandom_range(0, 4));
      proto_value_i <= $urandom_range(0, 1) ? pro : 8'($urandom);
      ttl_mode_i <= iacl_tri_t'($urandom_range(0, 2));
      frag_mode_i <= iacl_tri_t'($urandom_range(0, 2));
      opt_mode_i <= iacl_tri_t'($urandom_range(0, 2));
      src_mode_i <= iacl_addr_t'($urandom_range(0, 2));
      dst_mode_i <= iacl_addr_t'($urandom_range(0, 2));
      source_ipv4_address_i <= $urandom_range(0, 1) ? s : s ^ (32'h1 << $urandom_range(0, 31));
      source_ipv4_mask_i <= 32'hFFFFFFFF << $urandom_range(0, 32);
      destination_ipv4_address_i <= $urandom_range(0, 1) ? d : d ^ (32'h1 << $urandom_range(0, 31));
      destination_ipv4_mask_i <= 32'hFFFFFFFF << $urandom_range(0, 32);
      send <= 1'b1;
      @(posedge clock_i);
      send <= 1'b0;
      @(negedge clock_i);
      chk("hit_valid_idle", {3'h0, hit_valid_o}, 4'h0);
      chk("result_held", {hit_o, icmp_crit_en_o, port_crit_en_o, tcp_crit_en_o}, e);
      @(posedge clock_i);
      @(negedge clock_i);
      e = exp_out();
      chk("hit_valid_o", {3'h0, hit_valid_o}, 4'h1);
      chk("hit_o", {3'h0, hit_o}, {3'h0, e[3]});
      chk("crit_en", {1'b0, icmp_crit_en_o, port_crit_en_o, tcp_crit_en_o}, {1'b0, e[2:0]});
    end
    close_out();
  end
endmodule : ipv4_acl_entry_matcher_tb
`default_nettype wire
